// File: comparator_control_logic.v
// Control and status logic around an on-chip voltage comparator, reached over APB.
// Assumes a single 10 MHz clock, an asynchronous comparator output and an APB master on the same clock.
`timescale 1ns/10ps
`include "comparator_control_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - One 16-bit memory-mapped control register holds all settings except the interrupt mask, and both edge flags.
// - Comparator is powered only while the enable bit is one.
// - Negative input select: 00 reference, 01 analog output, 10 converter pin, 11 reserved.
// - Routing bits 7-6: 00 converter start, 01 pin, 10 logic array, 11 interrupt.
// - Polarity bit 5 low: high when positive above negative; high inverts this.
// - Bit 2 set enables about 7.5mV hysteresis; cleared gives none.
// - Rising edge sets flag bit 1; writing one to it clears it.
// - Falling edge sets flag bit 0; it stays set until software clears it.
module comparator_control_logic #(
  parameter ADDR_W = `CMP_ADDR_W,
  parameter DATA_W = `CMP_DATA_W
) (
  // Clock, reset and clock enable.
  input wire I_REF_CLK,
  input wire I_RESETN,
  input wire I_CE,
  // APB slave.
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [ADDR_W-1:0] I_PADDR,
  input wire [DATA_W-1:0] I_PWDATA,
  output wire [DATA_W-1:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  // Analog comparator.
  input wire I_CMP_RAW,
  output wire O_CMP_POWER_EN,
  output wire [1:0] O_NEG_INPUT_SEL,
  output wire O_HYST_EN,
  // Routed result.
  output wire O_ADC_START,
  output wire O_CMP_OUT_PIN,
  output wire O_CMP_OUT_PIN_OE,
  output wire O_PLA_IN,
  output wire O_CMP_IRQ,
  // Block interrupt.
  output wire O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.
  function [ADDR_W-1:0] word_addr;
    input [ADDR_W-1:0] addr;
    begin
      word_addr = {addr[ADDR_W-1:2], 2'b00};
    end
  endfunction

  function sticky_next;
    input cur;
    input set;
    input clr;
    begin
      // Set wins over a clear arriving in the same cycle.
      sticky_next = set | (cur & ~clr);
    end
  endfunction

  function route_is;
    input [1:0] sel;
    input [1:0] code;
    begin
      route_is = (sel == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  reg rd_pending_reg;
  reg [DATA_W-1:0] prdata_reg;
  reg [DATA_W-1:0] rd_value;
  wire [ADDR_W-1:0] addr_w;
  wire sel_control;
  wire sel_status;
  wire sel_mask;
  wire sel_live;
  wire mapped;
  wire access_done;
  wire wr_en;

  assign addr_w = word_addr(I_PADDR);
  assign sel_control = (addr_w == `CMP_OFF_CONTROL);
  assign sel_status = (addr_w == `CMP_OFF_IRQ_STATUS);
  assign sel_mask = (addr_w == `CMP_OFF_IRQ_MASK);
  assign sel_live = (addr_w == `CMP_OFF_LIVE);
  assign mapped = sel_control | sel_status | sel_mask | sel_live;
  assign O_PREADY = I_CE & rd_pending_reg;
  assign access_done = I_PSEL & I_PENABLE & O_PREADY;
  assign wr_en = access_done & I_PWRITE & mapped;
  assign O_PSLVERR = access_done & ~mapped;
  assign O_PRDATA = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser and edge detection.
  reg cmp_s1_reg;
  reg cmp_s2_reg;
  reg cmp_s3_reg;
  reg cmp_level_reg;
  reg cmp_prev_reg;
  reg cmp_armed_reg;
  reg adc_start_reg;
  wire cmp_level_next;
  wire polarised;
  wire monitored;
  wire [1:0] live_value;
  wire rise_evt;
  wire fall_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Control and interrupt registers.
  reg cmp_enable_reg;
  reg [1:0] neg_input_select_reg;
  reg [1:0] output_routing_select_reg;
  reg output_polarity_reg;
  reg hysteresis_enable_reg;
  reg rising_edge_flag_reg;
  reg falling_edge_flag_reg;
  reg [`CMP_EVT_W-1:0] irq_status_reg;
  reg [`CMP_EVT_W-1:0] irq_mask_reg;
  wire [`CMP_CTRL_W-1:0] control_value;
  wire [`CMP_EVT_W-1:0] evt_vec;
  wire wr_control;
  wire wr_status;
  wire wr_mask;
  wire [1:0] insel_wr;
  wire rise_clr;
  wire fall_clr;
  wire [`CMP_EVT_W-1:0] status_clr;
  wire flag_any;

  assign wr_control = wr_en & sel_control;
  assign wr_status = wr_en & sel_status;
  assign wr_mask = wr_en & sel_mask;
  assign insel_wr = I_PWDATA[`CMP_FLD_INSEL_HI:`CMP_FLD_INSEL_LO];
  assign rise_clr = wr_control & I_PWDATA[`CMP_BIT_RISE];
  assign fall_clr = wr_control & I_PWDATA[`CMP_BIT_FALL];
  assign status_clr = {`CMP_EVT_W{wr_status}} & I_PWDATA[`CMP_EVT_W-1:0];
  assign flag_any = rising_edge_flag_reg | falling_edge_flag_reg;

  assign control_value = {
    5'h00,
    cmp_enable_reg,
    neg_input_select_reg,
    output_routing_select_reg,
    output_polarity_reg,
    2'h0,
    hysteresis_enable_reg,
    rising_edge_flag_reg,
    falling_edge_flag_reg
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; a new level is accepted once stages two and three agree.
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      cmp_s3_reg <= 1'b0;
      cmp_level_reg <= 1'b0;
    end else if (I_CE) begin
      cmp_s1_reg <= I_CMP_RAW;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      cmp_level_reg <= cmp_level_next;
    end
  end

  assign cmp_level_next = (cmp_s2_reg == cmp_s3_reg) ? cmp_s3_reg : cmp_level_reg;

  // Polarity is applied after synchronisation so a polarity write looks like a transition.
  assign polarised = cmp_level_reg ^ output_polarity_reg;
  assign monitored = cmp_enable_reg & polarised;
  assign live_value = {cmp_level_reg, monitored};

  // The previous level follows the input even while disabled.
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_reg <= 1'b0;
    end else if (I_CE) begin
      cmp_prev_reg <= polarised;
    end
  end

  // Edges wait one cycle after enabling, so an enable write with any polarity makes no edge.
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_armed_reg <= 1'b0;
    end else if (I_CE) begin
      cmp_armed_reg <= cmp_enable_reg;
    end
  end

  assign rise_evt = cmp_armed_reg & monitored & ~cmp_prev_reg;
  assign fall_evt = cmp_armed_reg & cmp_enable_reg & ~polarised & cmp_prev_reg;
  assign evt_vec = {rise_evt, fall_evt};

  ////////////////////////////////////////////////////////////////////////////////
  // Control register.
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmp_enable_reg <= 1'b0;
      neg_input_select_reg <= `CMP_INSEL_REFERENCE;
      output_routing_select_reg <= `CMP_ROUTE_ADC_START;
      output_polarity_reg <= 1'b0;
      hysteresis_enable_reg <= 1'b0;
      rising_edge_flag_reg <= 1'b0;
      falling_edge_flag_reg <= 1'b0;
    end else if (I_CE) begin
      if (wr_control) begin
        cmp_enable_reg <= I_PWDATA[`CMP_BIT_ENABLE];
        if (insel_wr != `CMP_INSEL_RESERVED) begin
          neg_input_select_reg <= insel_wr;
        end
        output_routing_select_reg <= I_PWDATA[`CMP_FLD_ROUTE_HI:`CMP_FLD_ROUTE_LO];
        output_polarity_reg <= I_PWDATA[`CMP_BIT_POLARITY];
        hysteresis_enable_reg <= I_PWDATA[`CMP_BIT_HYST];
      end
      rising_edge_flag_reg <= sticky_next(rising_edge_flag_reg, rise_evt, rise_clr);
      falling_edge_flag_reg <= sticky_next(falling_edge_flag_reg, fall_evt, fall_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.
  integer k;
  wire [`CMP_EVT_W-1:0] irq_pending;

  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= `CMP_IRQ_STATUS_RESET;
      irq_mask_reg <= `CMP_IRQ_MASK_RESET;
    end else if (I_CE) begin
      for (k = 0; k < `CMP_EVT_W; k = k + 1) begin
        irq_status_reg[k] <= sticky_next(irq_status_reg[k], evt_vec[k], status_clr[k]);
      end
      if (wr_mask) begin
        irq_mask_reg <= I_PWDATA[`CMP_EVT_W-1:0];
      end
    end
  end

  assign irq_pending = irq_status_reg & irq_mask_reg;
  assign O_IRQ = |irq_pending;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and handshake.
  // Writes and unmapped addresses read as zero.
  always @* begin
    rd_value = {DATA_W{1'b0}};
    if (!I_PWRITE) begin
      case (1'b1)
        sel_control: begin
          rd_value = {{(DATA_W-`CMP_CTRL_W){1'b0}}, control_value};
        end
        sel_status: begin
          rd_value = {{(DATA_W-`CMP_EVT_W){1'b0}}, irq_status_reg};
        end
        sel_mask: begin
          rd_value = {{(DATA_W-`CMP_EVT_W){1'b0}}, irq_mask_reg};
        end
        sel_live: begin
          rd_value = {{(DATA_W-2){1'b0}}, live_value};
        end
        default: begin
          rd_value = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_pending_reg <= 1'b0;
      prdata_reg <= {DATA_W{1'b0}};
    end else if (I_CE) begin
      if (I_PSEL && !I_PENABLE) begin
        rd_pending_reg <= 1'b1;
        prdata_reg <= rd_value;
      end else if (access_done) begin
        rd_pending_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog controls.
  assign O_CMP_POWER_EN = cmp_enable_reg;
  assign O_NEG_INPUT_SEL = neg_input_select_reg;
  assign O_HYST_EN = hysteresis_enable_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Output routing.
  // One-hot view of the routing field.
  wire route_adc;
  wire route_pin;
  wire route_pla;
  wire route_irq;

  assign route_adc = route_is(output_routing_select_reg, `CMP_ROUTE_ADC_START);
  assign route_pin = route_is(output_routing_select_reg, `CMP_ROUTE_PIN);
  assign route_pla = route_is(output_routing_select_reg, `CMP_ROUTE_PLA);
  assign route_irq = route_is(output_routing_select_reg, `CMP_ROUTE_IRQ);

  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      adc_start_reg <= 1'b0;
    end else if (I_CE) begin
      adc_start_reg <= rise_evt & route_adc;
    end
  end

  assign O_ADC_START = adc_start_reg;
  assign O_CMP_OUT_PIN = monitored & route_pin;
  assign O_CMP_OUT_PIN_OE = cmp_enable_reg & route_pin;
  assign O_PLA_IN = monitored & route_pla;
  assign O_CMP_IRQ = route_irq & flag_any;

endmodule

// File: comparator_control_defines.vh
// Register offsets, field positions, reset values and widths for the comparator control logic.
// Assumes it is included by bare name from the design file that needs it.
`ifndef COMPARATOR_CONTROL_DEFINES_VH
`define COMPARATOR_CONTROL_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Bus geometry.
`define CMP_ADDR_W 8
`define CMP_DATA_W 32
`define CMP_CTRL_W 16

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define CMP_OFF_CONTROL 8'h00
`define CMP_OFF_IRQ_STATUS 8'h04
`define CMP_OFF_IRQ_MASK 8'h08
`define CMP_OFF_LIVE 8'h0c

////////////////////////////////////////////////////////////////////////////////
// Control register fields.
`define CMP_BIT_ENABLE 10
`define CMP_FLD_INSEL_HI 9
`define CMP_FLD_INSEL_LO 8
`define CMP_FLD_ROUTE_HI 7
`define CMP_FLD_ROUTE_LO 6
`define CMP_BIT_POLARITY 5
`define CMP_BIT_HYST 2
`define CMP_BIT_RISE 1
`define CMP_BIT_FALL 0
`define CMP_CONTROL_RESET 16'h0000
`define CMP_CONTROL_WMASK 16'h07e4

////////////////////////////////////////////////////////////////////////////////
// Field codes.
`define CMP_INSEL_REFERENCE 2'h0
`define CMP_INSEL_ANALOG_OUT 2'h1
`define CMP_INSEL_CONV_PIN 2'h2
`define CMP_INSEL_RESERVED 2'h3
`define CMP_ROUTE_ADC_START 2'h0
`define CMP_ROUTE_PIN 2'h1
`define CMP_ROUTE_PLA 2'h2
`define CMP_ROUTE_IRQ 2'h3

////////////////////////////////////////////////////////////////////////////////
// Interrupt status and mask fields and reset values.
`define CMP_EVT_W 2
`define CMP_EVT_FALL 0
`define CMP_EVT_RISE 1
`define CMP_IRQ_STATUS_RESET 2'h0
`define CMP_IRQ_MASK_RESET 2'h0

`endif

// File: comparator_control_chk.sv
// Concurrent checks on the ports of the comparator control logic.
// Assumes only the top module ports; bound to every instance at the foot of this file.
`timescale 1ns/10ps
module comparator_control_chk #(
  parameter ADDR_W = 8,
  parameter DATA_W = 32
) (
  input wire I_REF_CLK, input wire I_RESETN, input wire I_CE,
  input wire I_PSEL, input wire I_PENABLE, input wire I_PWRITE,
  input wire [ADDR_W-1:0] I_PADDR, input wire [DATA_W-1:0] I_PWDATA,
  input wire [DATA_W-1:0] O_PRDATA, input wire O_PREADY, input wire O_PSLVERR,
  input wire I_CMP_RAW, input wire O_CMP_POWER_EN, input wire [1:0] O_NEG_INPUT_SEL,
  input wire O_HYST_EN, input wire O_ADC_START, input wire O_CMP_OUT_PIN,
  input wire O_CMP_OUT_PIN_OE, input wire O_PLA_IN, input wire O_CMP_IRQ, input wire O_IRQ
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  reg [DATA_W-1:0] wd_q;
  wire ctl_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR[ADDR_W-1:2] == 0;
  always @(posedge I_REF_CLK) begin
    wd_q <= I_PWDATA;
  end
  property p_fields;
    ctl_wr && I_PWDATA[9:8] != 2'h3 |=> O_NEG_INPUT_SEL == wd_q[9:8] && O_CMP_POWER_EN == wd_q[10]
      && O_HYST_EN == wd_q[2];
  endproperty
  a_fields: assert property (p_fields) else $error("control write not applied");
  property p_reserved;
    ctl_wr && I_PWDATA[9:8] == 2'h3 |=> $stable(O_NEG_INPUT_SEL);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved select code taken");
  property p_pready;
    I_PSEL && !I_PENABLE && I_CE ##1 I_CE |-> O_PREADY;
  endproperty
  a_pready: assert property (p_pready) else $error("no ready in access cycle");
  property p_ce_ready;
    !I_CE |-> !O_PREADY;
  endproperty
  a_ce_ready: assert property (p_ce_ready) else $error("ready while clock enable low");
  property p_slverr;
    I_PSEL && I_PENABLE && O_PREADY |-> O_PSLVERR == (I_PADDR > 8'h0f);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_off;
    !O_CMP_POWER_EN |-> !O_CMP_OUT_PIN_OE && !O_CMP_OUT_PIN && !O_PLA_IN;
  endproperty
  a_off: assert property (p_off) else $error("result routed while disabled");
  property p_adc_excl;
    O_ADC_START |-> !$past(O_CMP_OUT_PIN_OE) && !$past(O_PLA_IN) && !$past(O_CMP_IRQ);
  endproperty
  a_adc_excl: assert property (p_adc_excl) else $error("start pulse with other routing");
  property p_adc_pulse;
    O_ADC_START |=> !O_ADC_START;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse too long");
  property p_pin_oe;
    O_CMP_OUT_PIN |-> O_CMP_OUT_PIN_OE;
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin high without enable");
  property p_irq_excl;
    O_CMP_IRQ |-> !O_CMP_OUT_PIN_OE && !O_PLA_IN;
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("interrupt with other routing");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind comparator_control_logic comparator_control_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_CMP_RAW(I_CMP_RAW), .O_CMP_POWER_EN(O_CMP_POWER_EN),
  .O_NEG_INPUT_SEL(O_NEG_INPUT_SEL), .O_HYST_EN(O_HYST_EN), .O_ADC_START(O_ADC_START),
  .O_CMP_OUT_PIN(O_CMP_OUT_PIN), .O_CMP_OUT_PIN_OE(O_CMP_OUT_PIN_OE), .O_PLA_IN(O_PLA_IN),
  .O_CMP_IRQ(O_CMP_IRQ), .O_IRQ(O_IRQ));

// File: tb.sv
// Self-checking testbench for the comparator control logic.
// Assumes an APB slave that answers by ready and a raw comparator input driven here.
`timescale 1ns/10ps
module tb;
  reg clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, raw = 0, ce = 1, e;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, r;
  wire [31:0] prdata;
  wire [1:0] nsel;
  wire pready, pslverr, pwr_en, hyst, adc, pin, pin_oe, programmable_logic_array, cirq, irq;
  integer n_fail = 0, comparisons = 0, cnt, i;
  comparator_control_logic dut (.I_REF_CLK(clk), .I_RESETN(rstn), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CMP_RAW(raw), .O_CMP_POWER_EN(pwr_en),
    .O_NEG_INPUT_SEL(nsel), .O_HYST_EN(hyst), .O_ADC_START(adc), .O_CMP_OUT_PIN(pin),
    .O_CMP_OUT_PIN_OE(pin_oe), .O_PLA_IN(programmable_logic_array), .O_CMP_IRQ(cirq), .O_IRQ(irq));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    begin
      if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp, input string nm);
    begin
      apb(0, a, 0);
      chk(nm, exp, r);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h0, "control");
    rd(8'h04, 32'h0, "status");
    rd(8'h08, 32'h0, "mask");
    apb(1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_04e4, "control");
    chk("power", 1, pwr_en);
    chk("hyst", 1, hyst);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1, 8'h00, 32'h0400 | (i << 8));
      chk("insel", i, nsel);
    end
    apb(0, 8'h10, 0);
    chk("unmapped", 1, {r[30:0], e});
    apb(1, 8'h00, 32'h0403);
    apb(1, 8'h04, 32'h3);
    apb(1, 8'h08, 32'h3);
    raw <= 1;
    cnt = 0;
    repeat (10) begin @(posedge clk); if (adc === 1'b1) cnt = cnt + 1; end
    chk("adc_pulses", 1, cnt);
    rd(8'h00, 32'h0402, "control");
    raw <= 0;
    repeat (8) @(posedge clk);
    rd(8'h00, 32'h0403, "control");
    rd(8'h04, 32'h3, "status");
    chk("irq", 1, irq);
    apb(1, 8'h04, 32'h3);
    chk("irq", 0, irq);
    apb(1, 8'h00, 32'h0403);
    rd(8'h00, 32'h0400, "control");
    raw <= 1;
    apb(1, 8'h00, 32'h0440);
    repeat (6) @(posedge clk);
    chk("pin", 32'h3, {pin_oe, pin});
    rd(8'h0c, 32'h3, "live");
    apb(1, 8'h00, 32'h0460);
    chk("pin", 32'h2, {pin_oe, pin});
    apb(1, 8'h00, 32'h04a0);
    chk("pla", 0, programmable_logic_array);
    apb(1, 8'h00, 32'h0480);
    chk("pla", 1, programmable_logic_array);
    apb(1, 8'h00, 32'h04c0);
    chk("cmp_irq", 1, cirq);
    apb(1, 8'h00, 32'h04c3);
    chk("cmp_irq", 0, cirq);
    apb(1, 8'h00, 32'h0000);
    chk("off", 0, {pwr_en, pin_oe, programmable_logic_array});
    apb(1, 8'h00, 32'h04c3);
    apb(1, 8'h04, 32'h3);
    ce <= 1'b0;
    raw <= 1'b0;
    repeat (10) @(posedge clk);
    chk("frozen", 0, {irq, cirq});
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk("thawed", 3, {irq, cirq});
    report_and_stop;
  end
endmodule
